// >>> design/irc_regs.sv
`timescale 1ns/1ps
// Overview of operation
// - Bit 7 enables reference test receiver
// - Bit 6 makes secondary reference differential
// - Bit 5 makes primary reference differential
// - Bit 2 clear keeps both references enabled
// - Bit 4 enables secondary when bit 2 set
// - Bit 3 enables primary when bit 2 set
// - Bit 1 picks oscillator negative pin
// - Bit 0 makes oscillator input differential
// - Second register bits 7:6 reserved, zero
// - Bit 5 selects internal zero delay path
// - Bit 4 selects oscillator loop feedback
// - Bit 3 picks zero delay single pin
// - Bit 2 makes zero delay input differential
// - Bit 1 picks secondary reference pin
// - Bit 0 picks primary reference pin
// - Writes buffered until update; selectable readback
module irc_regs
  import irc_pkg::*;
#(
  parameter int unsigned ADDR_W = IRC_ADDR_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [IRC_DATA_W-1:0] reg_wdata,
  input wire logic reg_rd,
  output logic [IRC_DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  // Update and readback control
  input wire logic io_update,
  input wire logic readback_buffered,
  // Reference receivers
  output logic ref_test_en,
  output logic primary_reference_en,
  output logic secondary_reference_en,
  output logic primary_reference_diff,
  output logic secondary_reference_diff,
  output logic primary_reference_pin_sel,
  output logic secondary_reference_pin_sel,
  // Oscillator input receiver
  output logic oscillator_input_diff,
  output logic oscillator_input_neg_sel,
  // Zero delay receiver and loop feedback
  output logic zero_delay_input_en,
  output logic zero_delay_input_diff,
  output logic zero_delay_input_pin_sel,
  output logic input_loop_osc_feedback,
  output logic input_loop_zd_internal
);

  logic rst_meta_ff;
  logic rst_sync_ff;
  logic rst_n;

  logic [IRC_DATA_W-1:0] buf_enable_mode_ff;
  logic [IRC_DATA_W-1:0] buf_fb_pin_sel_ff;
  logic [IRC_DATA_W-1:0] act_enable_mode_ff;
  logic [IRC_DATA_W-1:0] act_fb_pin_sel_ff;
  logic [IRC_DATA_W-1:0] nxt_buf_enable_mode;
  logic [IRC_DATA_W-1:0] nxt_buf_fb_pin_sel;
  logic [IRC_DATA_W-1:0] nxt_reg_rdata;
  logic hit_enable_mode;
  logic hit_fb_pin_sel;

  irc_cfg_if cfg ();

  // Reset release through two stages
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  assign rst_n = rst_sync_ff;

  assign hit_enable_mode = (reg_addr == ADDR_W'(IRC_OFS_ENABLE_MODE));
  assign hit_fb_pin_sel = (reg_addr == ADDR_W'(IRC_OFS_FB_PIN_SEL));

  // Buffered copy takes every write at once
  always_comb begin
    nxt_buf_enable_mode = buf_enable_mode_ff;
    nxt_buf_fb_pin_sel = buf_fb_pin_sel_ff;
    if (reg_wr && hit_enable_mode) begin
      nxt_buf_enable_mode = reg_wdata;
    end
    if (reg_wr && hit_fb_pin_sel) begin
      // Reserved bits never store, so they stay zero
      nxt_buf_fb_pin_sel = reg_wdata & IRC_FB_PIN_SEL_MASK;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      buf_enable_mode_ff <= IRC_RST_ENABLE_MODE;
      buf_fb_pin_sel_ff <= IRC_RST_FB_PIN_SEL;
    end else begin
      buf_enable_mode_ff <= nxt_buf_enable_mode;
      buf_fb_pin_sel_ff <= nxt_buf_fb_pin_sel;
    end
  end

  // Update applies the buffer including a write landing in the same cycle,
  // so a write is never lost to a coincident update
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      act_enable_mode_ff <= IRC_RST_ENABLE_MODE;
      act_fb_pin_sel_ff <= IRC_RST_FB_PIN_SEL;
    end else if (io_update) begin
      act_enable_mode_ff <= nxt_buf_enable_mode;
      act_fb_pin_sel_ff <= nxt_buf_fb_pin_sel;
    end
  end

  // Readback of active or buffered contents
  always_comb begin
    case ({hit_enable_mode, hit_fb_pin_sel})
      2'b10: begin
        nxt_reg_rdata = readback_buffered ? buf_enable_mode_ff : act_enable_mode_ff;
      end
      2'b01: begin
        nxt_reg_rdata = readback_buffered ? buf_fb_pin_sel_ff : act_fb_pin_sel_ff;
      end
      default: begin
        nxt_reg_rdata = IRC_UNMAPPED_RD;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= IRC_UNMAPPED_RD;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= nxt_reg_rdata;
      end
    end
  end

  // Decode sees only the active copy
  assign cfg.enable_mode = act_enable_mode_ff;
  assign cfg.fb_pin_sel = act_fb_pin_sel_ff;

  irc_decode u_decode (
    .cfg(cfg.dec)
  );

  assign ref_test_en = cfg.ref_test_en;
  assign primary_reference_en = cfg.primary_reference_en;
  assign secondary_reference_en = cfg.secondary_reference_en;
  assign primary_reference_diff = cfg.primary_reference_diff;
  assign secondary_reference_diff = cfg.secondary_reference_diff;
  assign primary_reference_pin_sel = cfg.primary_reference_pin_sel;
  assign secondary_reference_pin_sel = cfg.secondary_reference_pin_sel;
  assign oscillator_input_diff = cfg.oscillator_input_diff;
  assign oscillator_input_neg_sel = cfg.oscillator_input_neg_sel;
  assign zero_delay_input_en = cfg.zero_delay_input_en;
  assign zero_delay_input_diff = cfg.zero_delay_input_diff;
  assign zero_delay_input_pin_sel = cfg.zero_delay_input_pin_sel;
  assign input_loop_osc_feedback = cfg.input_loop_osc_feedback;
  assign input_loop_zd_internal = cfg.input_loop_zd_internal;

  default clocking cb @(posedge clk);
  endclocking

  default disable iff (!rst_n);

  sequence write_first_s;
    reg_wr && hit_enable_mode && !io_update;
  endsequence

  sequence update_s;
    io_update;
  endsequence

  sequence read_active_first_s;
    reg_rd && hit_enable_mode && !readback_buffered;
  endsequence

  sequence write_second_s;
    reg_wr && hit_fb_pin_sel;
  endsequence

  // Write alone must not reach the receivers
  property write_held_p;
    write_first_s |=> $stable(act_enable_mode_ff);
  endproperty

  // Update after a quiet buffer applies what was written
  property update_applies_p;
    (write_first_s ##1 (update_s and (!reg_wr))) |=>
      act_enable_mode_ff == $past(reg_wdata, 2);
  endproperty

  held_write_a: assert property (write_held_p)
    else $error("write reached active copy without update");

  apply_update_a: assert property (update_applies_p)
    else $error("update did not apply buffered value");

  read_active_a: assert property (read_active_first_s |=>
      reg_rvalid && reg_rdata == $past(act_enable_mode_ff))
    else $error("active readback mismatch");

  read_buffered_a: assert property (
      (reg_rd && hit_fb_pin_sel && readback_buffered) |=>
      reg_rvalid && reg_rdata == $past(buf_fb_pin_sel_ff))
    else $error("buffered readback mismatch");

  reserved_zero_a: assert property (
      buf_fb_pin_sel_ff[IRC_B_RSVD_HI:IRC_B_RSVD_LO] == 2'h0 &&
      act_fb_pin_sel_ff[IRC_B_RSVD_HI:IRC_B_RSVD_LO] == 2'h0)
    else $error("reserved bits not zero");

  outputs_stable_a: assert property (!io_update |=>
      $stable({ref_test_en, primary_reference_en, secondary_reference_en,
               zero_delay_input_en, input_loop_osc_feedback}))
    else $error("receiver control moved without update");

  test_rx_enable_a: assert property (
      ref_test_en == act_enable_mode_ff[IRC_A_REF_TEST_EN])
    else $error("reference test enable mismatch");

  pd_gate_off_a: assert property (!act_enable_mode_ff[IRC_A_PD_CTRL_EN] |->
      primary_reference_en && secondary_reference_en)
    else $error("reference powered down without control enable");

  sec_pd_ctrl_a: assert property (act_enable_mode_ff[IRC_A_PD_CTRL_EN] |->
      secondary_reference_en == act_enable_mode_ff[IRC_A_SEC_EN])
    else $error("secondary enable mismatch");

  pri_pd_ctrl_a: assert property (act_enable_mode_ff[IRC_A_PD_CTRL_EN] |->
      primary_reference_en == act_enable_mode_ff[IRC_A_PRI_EN])
    else $error("primary enable mismatch");

  ref_modes_a: assert property (
      secondary_reference_diff == act_enable_mode_ff[IRC_A_SEC_DIFF] &&
      primary_reference_diff == act_enable_mode_ff[IRC_A_PRI_DIFF])
    else $error("reference mode mismatch");

  osc_pin_a: assert property (!act_enable_mode_ff[IRC_A_OSC_DIFF] |->
      oscillator_input_neg_sel == act_enable_mode_ff[IRC_A_OSC_NEG_SEL] &&
      !oscillator_input_diff)
    else $error("oscillator pin select mismatch");

  zd_ignored_a: assert property (act_fb_pin_sel_ff[IRC_B_OSC_FEEDBACK] |->
      input_loop_osc_feedback && !input_loop_zd_internal &&
      !zero_delay_input_en)
    else $error("zero delay active under oscillator feedback");

  zd_mode_a: assert property (!act_fb_pin_sel_ff[IRC_B_OSC_FEEDBACK] |->
      zero_delay_input_en == !act_fb_pin_sel_ff[IRC_B_ZD_INTERNAL] &&
      input_loop_zd_internal == act_fb_pin_sel_ff[IRC_B_ZD_INTERNAL])
    else $error("zero delay mode mismatch");

  zd_pin_a: assert property (!act_fb_pin_sel_ff[IRC_B_ZD_DIFF] |->
      zero_delay_input_pin_sel == act_fb_pin_sel_ff[IRC_B_ZD_PIN_SEL] &&
      !zero_delay_input_diff)
    else $error("zero delay pin select mismatch");

  ref_pins_a: assert property (
      (!act_enable_mode_ff[IRC_A_SEC_DIFF] |->
        secondary_reference_pin_sel == act_fb_pin_sel_ff[IRC_B_SEC_PIN_SEL]) and
      (!act_enable_mode_ff[IRC_A_PRI_DIFF] |->
        primary_reference_pin_sel == act_fb_pin_sel_ff[IRC_B_PRI_PIN_SEL]))
    else $error("reference pin select mismatch");

  rvalid_pulse_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read answer missing");

  rvalid_idle_a: assert property (!reg_rd |=> !reg_rvalid)
    else $error("read answer without request");

  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");

  unmapped_read_a: assert property (
      (reg_rd && !hit_enable_mode && !hit_fb_pin_sel) |=>
      reg_rdata == IRC_UNMAPPED_RD)
    else $error("unmapped read not zero");

  buf_write_a: assert property (write_first_s |=>
      buf_enable_mode_ff == $past(reg_wdata))
    else $error("first register write not buffered");

  fb_write_a: assert property (write_second_s |=>
      buf_fb_pin_sel_ff == ($past(reg_wdata) & IRC_FB_PIN_SEL_MASK))
    else $error("second register write not buffered");

  same_cycle_apply_a: assert property ((write_second_s and update_s) |=>
      act_fb_pin_sel_ff == ($past(reg_wdata) & IRC_FB_PIN_SEL_MASK))
    else $error("write lost to coincident update");

  buf_quiet_a: assert property (!reg_wr |=>
      $stable(buf_enable_mode_ff) && $stable(buf_fb_pin_sel_ff))
    else $error("buffer moved without a write");

  active_quiet_a: assert property (!io_update |=>
      $stable(act_enable_mode_ff) && $stable(act_fb_pin_sel_ff))
    else $error("active copy moved without update");

endmodule

// >>> include/irc_pkg.sv
package irc_pkg;

  localparam int unsigned IRC_ADDR_W = 13;
  localparam int unsigned IRC_DATA_W = 8;

  // Register offsets
  localparam logic [IRC_ADDR_W-1:0] IRC_OFS_ENABLE_MODE = 13'h01a;
  localparam logic [IRC_ADDR_W-1:0] IRC_OFS_FB_PIN_SEL = 13'h01b;

  // Reset values
  localparam logic [IRC_DATA_W-1:0] IRC_RST_ENABLE_MODE = 8'h00;
  localparam logic [IRC_DATA_W-1:0] IRC_RST_FB_PIN_SEL = 8'h00;

  // Value returned for an unmapped read
  localparam logic [IRC_DATA_W-1:0] IRC_UNMAPPED_RD = 8'h00;

  // Writable bits of the second register; bits 7:6 are reserved
  localparam logic [IRC_DATA_W-1:0] IRC_FB_PIN_SEL_MASK = 8'h3f;

  // input_receiver_enable_mode field positions
  localparam int unsigned IRC_A_REF_TEST_EN = 7;
  localparam int unsigned IRC_A_SEC_DIFF = 6;
  localparam int unsigned IRC_A_PRI_DIFF = 5;
  localparam int unsigned IRC_A_SEC_EN = 4;
  localparam int unsigned IRC_A_PRI_EN = 3;
  localparam int unsigned IRC_A_PD_CTRL_EN = 2;
  localparam int unsigned IRC_A_OSC_NEG_SEL = 1;
  localparam int unsigned IRC_A_OSC_DIFF = 0;

  // feedback_and_pin_select field positions
  localparam int unsigned IRC_B_RSVD_HI = 7;
  localparam int unsigned IRC_B_RSVD_LO = 6;
  localparam int unsigned IRC_B_ZD_INTERNAL = 5;
  localparam int unsigned IRC_B_OSC_FEEDBACK = 4;
  localparam int unsigned IRC_B_ZD_PIN_SEL = 3;
  localparam int unsigned IRC_B_ZD_DIFF = 2;
  localparam int unsigned IRC_B_SEC_PIN_SEL = 1;
  localparam int unsigned IRC_B_PRI_PIN_SEL = 0;

endpackage

// >>> include/irc_cfg_if.sv
`timescale 1ns/1ps
interface irc_cfg_if;
  import irc_pkg::*;

  // Active register contents
  logic [IRC_DATA_W-1:0] enable_mode;
  logic [IRC_DATA_W-1:0] fb_pin_sel;

  // Decoded receiver controls
  logic ref_test_en;
  logic primary_reference_en;
  logic secondary_reference_en;
  logic primary_reference_diff;
  logic secondary_reference_diff;
  logic primary_reference_pin_sel;
  logic secondary_reference_pin_sel;
  logic oscillator_input_diff;
  logic oscillator_input_neg_sel;
  logic zero_delay_input_en;
  logic zero_delay_input_diff;
  logic zero_delay_input_pin_sel;
  logic input_loop_osc_feedback;
  logic input_loop_zd_internal;

  modport regs (
    output enable_mode,
    output fb_pin_sel,
    input ref_test_en,
    input primary_reference_en,
    input secondary_reference_en,
    input primary_reference_diff,
    input secondary_reference_diff,
    input primary_reference_pin_sel,
    input secondary_reference_pin_sel,
    input oscillator_input_diff,
    input oscillator_input_neg_sel,
    input zero_delay_input_en,
    input zero_delay_input_diff,
    input zero_delay_input_pin_sel,
    input input_loop_osc_feedback,
    input input_loop_zd_internal
  );

  modport dec (
    input enable_mode,
    input fb_pin_sel,
    output ref_test_en,
    output primary_reference_en,
    output secondary_reference_en,
    output primary_reference_diff,
    output secondary_reference_diff,
    output primary_reference_pin_sel,
    output secondary_reference_pin_sel,
    output oscillator_input_diff,
    output oscillator_input_neg_sel,
    output zero_delay_input_en,
    output zero_delay_input_diff,
    output zero_delay_input_pin_sel,
    output input_loop_osc_feedback,
    output input_loop_zd_internal
  );
endinterface

// >>> design/irc_decode.sv
`timescale 1ns/1ps
module irc_decode
  import irc_pkg::*;
(
  // Active contents in, receiver controls out
  irc_cfg_if.dec cfg
);

  logic pd_ctrl;
  logic osc_fb;

  assign pd_ctrl = cfg.enable_mode[IRC_A_PD_CTRL_EN];
  assign osc_fb = cfg.fb_pin_sel[IRC_B_OSC_FEEDBACK];

  // Pure decode, so outputs move only when the active copy moves
  assign cfg.ref_test_en = cfg.enable_mode[IRC_A_REF_TEST_EN];
  assign cfg.secondary_reference_diff = cfg.enable_mode[IRC_A_SEC_DIFF];
  assign cfg.primary_reference_diff = cfg.enable_mode[IRC_A_PRI_DIFF];
  // Individual enables count only while power-down control is on
  assign cfg.secondary_reference_en = !pd_ctrl || cfg.enable_mode[IRC_A_SEC_EN];
  assign cfg.primary_reference_en = !pd_ctrl || cfg.enable_mode[IRC_A_PRI_EN];
  assign cfg.oscillator_input_diff = cfg.enable_mode[IRC_A_OSC_DIFF];
  // Pin selects are forced low in differential mode, where they mean nothing
  assign cfg.oscillator_input_neg_sel =
    !cfg.enable_mode[IRC_A_OSC_DIFF] && cfg.enable_mode[IRC_A_OSC_NEG_SEL];
  assign cfg.secondary_reference_pin_sel =
    !cfg.enable_mode[IRC_A_SEC_DIFF] && cfg.fb_pin_sel[IRC_B_SEC_PIN_SEL];
  assign cfg.primary_reference_pin_sel =
    !cfg.enable_mode[IRC_A_PRI_DIFF] && cfg.fb_pin_sel[IRC_B_PRI_PIN_SEL];
  assign cfg.zero_delay_input_diff = cfg.fb_pin_sel[IRC_B_ZD_DIFF];
  assign cfg.zero_delay_input_pin_sel =
    !cfg.fb_pin_sel[IRC_B_ZD_DIFF] && cfg.fb_pin_sel[IRC_B_ZD_PIN_SEL];
  assign cfg.input_loop_osc_feedback = osc_fb;
  // Zero delay mode bit is ignored under local oscillator feedback
  assign cfg.input_loop_zd_internal = !osc_fb && cfg.fb_pin_sel[IRC_B_ZD_INTERNAL];
  assign cfg.zero_delay_input_en = !osc_fb && !cfg.fb_pin_sel[IRC_B_ZD_INTERNAL];

endmodule

// >>> testbench/tb.sv
`timescale 1ns/1ps
module tb;
  import irc_pkg::*;

  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [IRC_ADDR_W-1:0] reg_addr = '0;
  logic reg_wr = 1'b0;
  logic [IRC_DATA_W-1:0] reg_wdata = '0;
  logic reg_rd = 1'b0;
  logic [IRC_DATA_W-1:0] reg_rdata;
  logic reg_rvalid;
  logic io_update = 1'b0;
  logic readback_buffered = 1'b0;
  logic [13:0] dec;
  int error_cnt = 0;
  int n_tests = 0;
  int buf_a = 0;
  int buf_b = 0;
  int act_a = 0;
  int act_b = 0;
  integer seed = 32'h5b49;

  always #50 clk = ~clk;

  irc_regs u_dut (
    .clk(clk),
    .resetn(resetn),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_wdata(reg_wdata),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid),
    .io_update(io_update),
    .readback_buffered(readback_buffered),
    .ref_test_en(dec[13]),
    .primary_reference_en(dec[12]),
    .secondary_reference_en(dec[11]),
    .primary_reference_diff(dec[10]),
    .secondary_reference_diff(dec[9]),
    .primary_reference_pin_sel(dec[8]),
    .secondary_reference_pin_sel(dec[7]),
    .oscillator_input_diff(dec[6]),
    .oscillator_input_neg_sel(dec[5]),
    .zero_delay_input_en(dec[4]),
    .zero_delay_input_diff(dec[3]),
    .zero_delay_input_pin_sel(dec[2]),
    .input_loop_osc_feedback(dec[1]),
    .input_loop_zd_internal(dec[0])
  );

  // Reference decode, same bit order as dec
  function automatic logic [13:0] exp_dec(input logic [7:0] a, input logic [7:0] b);
    logic [13:0] e;
    e[13] = a[7];
    e[12] = !(a[2] && !a[3]);
    e[11] = !(a[2] && !a[4]);
    e[10] = a[5];
    e[9] = a[6];
    e[8] = b[0] && !a[5];
    e[7] = b[1] && !a[6];
    e[6] = a[0];
    e[5] = a[1] && !a[0];
    e[4] = !b[4] && !b[5];
    e[3] = b[2];
    e[2] = b[3] && !b[2];
    e[1] = b[4];
    e[0] = !b[4] && b[5];
    return e;
  endfunction

  function automatic logic [7:0] model_rd(input logic [12:0] a, input logic m);
    if (a == 13'h01a) begin
      return m ? buf_a[7:0] : act_a[7:0];
    end
    if (a == 13'h01b) begin
      return m ? buf_b[7:0] : act_b[7:0];
    end
    return 8'h00;
  endfunction

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_out();
    logic [13:0] e;
    #1;
    e = exp_dec(act_a[7:0], act_b[7:0]);
    n_tests++;
    if (dec !== e) begin
      error_cnt++;
      $display("MISMATCH at %0t: decode got %b expected %b", $time, dec, e);
    end
  endtask

  // Write, optionally with an update in the same cycle
  task automatic wr(input logic [12:0] a, input logic [7:0] d, input logic u);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    io_update <= u;
    @(posedge clk);
    reg_wr <= 1'b0;
    io_update <= 1'b0;
    if (a == 13'h01a) buf_a = d;
    if (a == 13'h01b) buf_b = d & 8'h3f;
    if (u) begin
      act_a = buf_a;
      act_b = buf_b;
    end
  endtask

  task automatic upd();
    @(posedge clk);
    io_update <= 1'b1;
    @(posedge clk);
    io_update <= 1'b0;
    act_a = buf_a;
    act_b = buf_b;
  endtask

  // Write, then an update in the very next cycle
  task automatic wr_upd(input logic [12:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    io_update <= 1'b1;
    @(posedge clk);
    io_update <= 1'b0;
    if (a == 13'h01a) buf_a = d;
    if (a == 13'h01b) buf_b = d & 8'h3f;
    act_a = buf_a;
    act_b = buf_b;
  endtask

  task automatic rd(input logic [12:0] a, input logic m);
    logic [7:0] e;
    e = model_rd(a, m);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    readback_buffered <= m;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    // The answer is due exactly one cycle after the strobe
    n_tests++;
    if (reg_rvalid !== 1'b1) begin
      error_cnt++;
      $display("MISMATCH at %0t: read answer not in next cycle", $time);
      test_done();
    end else begin
      chk_val(reg_rdata, e, "read data");
    end
  endtask

  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);

    chk_out();
    for (int k = 0; k < 4; k++) begin
      rd(k[1] ? 13'h01b : 13'h01a, k[0]);
    end
    $display("Test reset values done");

    wr(13'h01a, 8'hff, 1'b0);
    chk_out();
    rd(13'h01a, 1'b1);
    rd(13'h01a, 1'b0);
    upd();
    chk_out();
    wr_upd(13'h01a, 8'h5a);
    chk_out();
    rd(13'h01a, 1'b0);
    $display("Test buffered update done");

    wr(13'h01b, 8'hff, 1'b0);
    rd(13'h01b, 1'b1);
    upd();
    rd(13'h01b, 1'b0);
    chk_out();
    $display("Test reserved bits done");

    wr(13'h01c, 8'h55, 1'b1);
    rd(13'h01c, 1'b0);
    rd(13'h01a, 1'b1);
    rd(13'h01b, 1'b0);
    $display("Test unmapped address done");

    // Every pattern of the first register against random second-register values
    for (int i = 0; i < 256; i++) begin
      wr(13'h01a, i[7:0], 1'b0);
      wr(13'h01b, 8'($random(seed)), i[0]);
      if (!i[0]) upd();
      chk_out();
      if (i[2:0] == 3'h3) rd(13'h01b, 1'($random(seed)));
    end
    $display("Test full decode sweep done");

    test_done();
  end
endmodule
